// ===== logic/rss_alu_core.sv
// Execution unit for rotate, subtract, skip, swap, set, table read and XOR operations.
`timescale 1ns/1ps
`default_nettype none
module rss_alu_core (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire logic [rss_pkg::BUS_AW-1:0]  avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [rss_pkg::BUS_DW-1:0]  avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output logic      [rss_pkg::BUS_DW-1:0]  avs_readdata,
	output logic                         avs_waitrequest,
	output logic      [rss_pkg::PROG_AW-1:0] prog_addr,
	output logic                         prog_rd,
	input  wire logic [rss_pkg::PROG_DW-1:0] prog_data,
	output logic                         skip_taken,
	output logic                         instr_done
);
	import rss_pkg::*;

	rss_mem_if mem ();

	rss_data_mem u_mem (
		.clk     (clk),
		.sys_rst (sys_rst),
		.port    (mem.store)
	);

	rss_state_t          state_reg;
	rss_state_t          state_next;
	rss_op_t             op_reg;
	logic [2:0]          bit_reg;
	logic [MEM_AW-1:0]   maddr_reg;
	logic [DATA_W-1:0]   imm_reg;
	logic [DATA_W-1:0]   acc_reg;
	logic                c_reg;
	logic                ac_reg;
	logic                z_reg;
	logic                ov_reg;
	logic                skip_reg;
	logic                done_reg;
	logic [DATA_W-1:0]   table_pointer_low_reg;
	logic [3:0]          table_pointer_high_reg;
	logic [DATA_W-1:0]   table_high_byte_reg_reg;
	logic [PROG_AW-1:0]  prog_addr_reg;
	logic [BUS_DW-1:0]   rdat_reg;
	logic                rd_mem_reg;

	// Bus decode.
	wire logic idle      = (state_reg == ST_IDLE);
	wire logic lane0     = avs_byteenable[0];
	wire logic hit_mem   = (avs_address[7:6] == MEM_WIN_SEL);
	wire logic bus_wr    = idle & avs_write & lane0;
	wire logic wr_op     = bus_wr & (avs_address == OFF_OPERATION);
	wire logic wr_acc    = bus_wr & (avs_address == OFF_ACC);
	wire logic wr_status = bus_wr & (avs_address == OFF_STATUS);
	wire logic wr_table_pointer_low   = bus_wr & (avs_address == OFF_TBL_LOW);
	wire logic wr_table_pointer_high   = bus_wr & (avs_address == OFF_TBL_HIGH);
	wire logic wr_mem    = bus_wr & hit_mem;
	wire logic rd_start  = idle & avs_read & ~avs_write;
	wire logic in_exec   = (state_reg == ST_EXEC);

	wire rss_op_t     new_op   = rss_op_t'(avs_writedata[OP_CODE_LSB +: 5]);
	wire logic [3:0]  new_page = HAS_HIGH_PTR ? table_pointer_high_reg : 4'h0;
	wire logic        last_pg  = (new_op == OP_TABLE_READ_LAST_PAGE);
	wire logic        is_table = (op_reg == OP_TABLE_READ_PAGED)
	                           | (op_reg == OP_TABLE_READ_LAST_PAGE);

	// Operand selection and arithmetic on the byte read from memory.
	wire logic [DATA_W-1:0] m_val    = mem.rdata;
	wire logic              use_imm  = (op_reg == OP_SUBTRACT_IMM)
	                                 | (op_reg == OP_EXCLUSIVE_OR_IMM);
	wire logic [DATA_W-1:0] sub_b    = use_imm ? imm_reg : m_val;
	wire logic              with_brw = (op_reg == OP_SUBTRACT_BORROW_TO_ACC)
	                                 | (op_reg == OP_SUBTRACT_BORROW_TO_MEM);
	wire logic              brw_in   = with_brw & ~c_reg;
	wire logic [DATA_W:0]   sub_full = {1'b0, acc_reg} - {1'b0, sub_b} - {8'h00, brw_in};
	wire logic [4:0]        sub_low  = {1'b0, acc_reg[3:0]} - {1'b0, sub_b[3:0]}
	                                 - {4'h0, brw_in};
	wire logic [DATA_W-1:0] sub_res  = sub_full[DATA_W-1:0];
	wire logic              sub_ov   = (acc_reg[7] ^ sub_b[7]) & (acc_reg[7] ^ sub_res[7]);
	wire logic [DATA_W-1:0] dec_res  = m_val - 8'h01;
	wire logic [DATA_W-1:0] inc_res  = m_val + 8'h01;
	wire logic [DATA_W-1:0] xor_res  = acc_reg ^ sub_b;
	wire logic [DATA_W-1:0] bit_mask = 8'h01 << bit_reg;
	wire logic              sel_bit  = m_val[bit_reg];

	logic [DATA_W-1:0] res;
	logic              to_acc;
	logic              to_mem;
	logic              upd_c;
	logic              c_new;
	logic              upd_arith;
	logic              upd_z;
	logic              skip_hit;

	always_comb begin
		res       = m_val;
		to_acc    = 1'b0;
		to_mem    = 1'b0;
		upd_c     = 1'b0;
		c_new     = c_reg;
		upd_arith = 1'b0;
		upd_z     = 1'b0;
		skip_hit  = 1'b0;
		unique case (op_reg)
			OP_ROTATE_LEFT_CARRY_TO_ACC: begin
				res    = {m_val[6:0], c_reg};
				to_acc = 1'b1;
				upd_c  = 1'b1;
				c_new  = m_val[7];
			end
			OP_ROTATE_RIGHT_MEM: begin
				res    = {m_val[0], m_val[7:1]};
				to_mem = 1'b1;
			end
			OP_ROTATE_RIGHT_TO_ACC: begin
				res    = {m_val[0], m_val[7:1]};
				to_acc = 1'b1;
			end
			OP_ROTATE_RIGHT_CARRY_MEM: begin
				res    = {c_reg, m_val[7:1]};
				to_mem = 1'b1;
				upd_c  = 1'b1;
				c_new  = m_val[0];
			end
			OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
				res    = {c_reg, m_val[7:1]};
				to_acc = 1'b1;
				upd_c  = 1'b1;
				c_new  = m_val[0];
			end
			OP_SUBTRACT_BORROW_TO_ACC, OP_SUBTRACT_TO_ACC, OP_SUBTRACT_IMM: begin
				res       = sub_res;
				to_acc    = 1'b1;
				upd_arith = 1'b1;
			end
			OP_SUBTRACT_BORROW_TO_MEM, OP_SUBTRACT_TO_MEM: begin
				res       = sub_res;
				to_mem    = 1'b1;
				upd_arith = 1'b1;
			end
			OP_DECREMENT_SKIP_ZERO: begin
				res      = dec_res;
				to_mem   = 1'b1;
				skip_hit = (dec_res == 8'h00);
			end
			OP_DECREMENT_SKIP_ZERO_ACC: begin
				res      = dec_res;
				to_acc   = 1'b1;
				skip_hit = (dec_res == 8'h00);
			end
			OP_INCREMENT_SKIP_ZERO: begin
				res      = inc_res;
				to_mem   = 1'b1;
				skip_hit = (inc_res == 8'h00);
			end
			OP_INCREMENT_SKIP_ZERO_ACC: begin
				res      = inc_res;
				to_acc   = 1'b1;
				skip_hit = (inc_res == 8'h00);
			end
			OP_SKIP_BIT_SET: begin
				skip_hit = sel_bit;
			end
			OP_SKIP_BIT_CLEAR: begin
				skip_hit = ~sel_bit;
			end
			OP_SKIP_IF_ZERO: begin
				to_mem   = 1'b1;
				skip_hit = (m_val == 8'h00);
			end
			OP_COPY_SKIP_IF_ZERO: begin
				to_acc   = 1'b1;
				skip_hit = (m_val == 8'h00);
			end
			OP_NIBBLE_SWAP_MEM: begin
				res    = {m_val[3:0], m_val[7:4]};
				to_mem = 1'b1;
			end
			OP_NIBBLE_SWAP_TO_ACC: begin
				res    = {m_val[3:0], m_val[7:4]};
				to_acc = 1'b1;
			end
			OP_BYTE_SET_MEM: begin
				res    = ALL_ONES;
				to_mem = 1'b1;
			end
			OP_BIT_SET_MEM: begin
				res    = m_val | bit_mask;
				to_mem = 1'b1;
			end
			OP_TABLE_READ_PAGED, OP_TABLE_READ_LAST_PAGE: begin
				res    = prog_data[7:0];
				to_mem = 1'b1;
			end
			OP_EXCLUSIVE_OR_TO_ACC, OP_EXCLUSIVE_OR_IMM: begin
				res    = xor_res;
				to_acc = 1'b1;
				upd_z  = 1'b1;
			end
			OP_EXCLUSIVE_OR_TO_MEM: begin
				res    = xor_res;
				to_mem = 1'b1;
				upd_z  = 1'b1;
			end
			default: begin
				res = m_val;
			end
		endcase
	end

	// Memory port: the bus owns it while idle, the executing operation otherwise.
	assign mem.addr  = idle ? avs_address[5:2] : maddr_reg;
	assign mem.rd    = (rd_start & hit_mem) | (state_reg == ST_FETCH);
	assign mem.wr    = wr_mem | (in_exec & to_mem);
	assign mem.wdata = idle ? avs_writedata[7:0] : res;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (wr_op) begin
					state_next = ST_FETCH;
				end else if (rd_start) begin
					state_next = ST_BUSRD;
				end
			end
			ST_FETCH: state_next = ST_EXEC;
			ST_EXEC:  state_next = skip_hit ? ST_SKIP : ST_IDLE;
			ST_SKIP:  state_next = ST_IDLE;
			ST_BUSRD: state_next = ST_IDLE;
			default:  state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Operation latch at start.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			op_reg        <= OP_ROTATE_LEFT_CARRY_TO_ACC;
			bit_reg       <= 3'h0;
			maddr_reg     <= '0;
			imm_reg       <= RST_BYTE;
			prog_addr_reg <= '0;
		end else if (wr_op) begin
			op_reg        <= new_op;
			bit_reg       <= avs_writedata[OP_BIT_LSB +: 3];
			maddr_reg     <= avs_writedata[OP_ADDR_LSB +: MEM_AW];
			imm_reg       <= avs_writedata[OP_IMM_LSB +: DATA_W];
			prog_addr_reg <= {(last_pg ? LAST_PAGE : new_page), table_pointer_low_reg};
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_reg <= RST_BYTE;
			c_reg   <= 1'b0;
			ac_reg  <= 1'b0;
			z_reg   <= 1'b0;
			ov_reg  <= 1'b0;
		end else if (in_exec) begin
			if (to_acc) begin
				acc_reg <= res;
			end
			if (upd_c) begin
				c_reg <= c_new;
			end
			if (upd_arith) begin
				c_reg  <= ~sub_full[DATA_W];
				ac_reg <= ~sub_low[4];
				ov_reg <= sub_ov;
			end
			if (upd_arith | upd_z) begin
				z_reg <= (res == 8'h00);
			end
		end else begin
			if (wr_acc) begin
				acc_reg <= avs_writedata[7:0];
			end
			if (wr_status) begin
				c_reg  <= avs_writedata[ST_C_BIT];
				ac_reg <= avs_writedata[ST_AC_BIT];
				z_reg  <= avs_writedata[ST_Z_BIT];
				ov_reg <= avs_writedata[ST_OV_BIT];
			end
		end
	end

	// Table pointers and the table high byte.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			table_pointer_low_reg <= RST_BYTE;
			table_pointer_high_reg <= 4'h0;
			table_high_byte_reg_reg <= RST_BYTE;
		end else begin
			if (wr_table_pointer_low) begin
				table_pointer_low_reg <= avs_writedata[7:0];
			end
			if (wr_table_pointer_high) begin
				table_pointer_high_reg <= avs_writedata[3:0];
			end
			if (in_exec & is_table) begin
				table_high_byte_reg_reg <= prog_data[15:8];
			end
		end
	end

	// Skip result and completion pulse.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			skip_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			if (in_exec) begin
				skip_reg <= skip_hit;
			end
			done_reg <= (in_exec & ~skip_hit) | (state_reg == ST_SKIP);
		end
	end

	// Register read data are captured when the read is first seen while idle, one cycle before it is accepted.
	wire logic [BUS_DW-1:0] reg_view =
		(avs_address == OFF_OPERATION) ? {8'h00, imm_reg, 4'h0, maddr_reg, bit_reg, op_reg} :
		(avs_address == OFF_ACC)       ? {24'h000000, acc_reg} :
		(avs_address == OFF_STATUS)    ? {26'h0, ~idle, skip_reg, ov_reg, z_reg,
		                                  ac_reg, c_reg} :
		(avs_address == OFF_TBL_LOW)   ? {24'h000000, table_pointer_low_reg} :
		(avs_address == OFF_TBL_HIGH)  ? {28'h0000000, table_pointer_high_reg} :
		(avs_address == OFF_TBL_DATA)  ? {24'h000000, table_high_byte_reg_reg} :
		32'h00000000;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdat_reg   <= 32'h00000000;
			rd_mem_reg <= 1'b0;
		end else if (rd_start) begin
			rdat_reg   <= reg_view;
			rd_mem_reg <= hit_mem;
		end
	end

	assign avs_readdata    = rd_mem_reg ? {24'h000000, mem.rdata} : rdat_reg;
	assign avs_waitrequest = ~((idle & avs_write) | (state_reg == ST_BUSRD));
	assign prog_addr       = prog_addr_reg;
	assign prog_rd         = (state_reg == ST_FETCH) & is_table;
	assign skip_taken      = (state_reg == ST_SKIP);
	assign instr_done      = done_reg;

endmodule // rss_alu_core
`default_nettype wire

// ===== logic/rss_pkg.sv
// Constants, types and register map of the rotate, subtract and skip execution unit.
package rss_pkg;

	localparam int unsigned DATA_W      = 8;
	localparam int unsigned MEM_AW      = 4;
	localparam int unsigned PROG_AW     = 12;
	localparam int unsigned PROG_DW     = 16;
	localparam int unsigned BUS_AW      = 8;
	localparam int unsigned BUS_DW      = 32;

	// Register byte offsets on the bus.
	localparam logic [7:0] OFF_OPERATION = 8'h00;
	localparam logic [7:0] OFF_ACC       = 8'h04;
	localparam logic [7:0] OFF_STATUS    = 8'h08;
	localparam logic [7:0] OFF_TBL_LOW   = 8'h0C;
	localparam logic [7:0] OFF_TBL_HIGH  = 8'h10;
	localparam logic [7:0] OFF_TBL_DATA  = 8'h14;
	// Data memory window: one byte per word, index in address bits 5:2.
	localparam logic [1:0] MEM_WIN_SEL   = 2'h1;

	// Operation register fields.
	localparam int unsigned OP_CODE_LSB  = 0;
	localparam int unsigned OP_BIT_LSB   = 5;
	localparam int unsigned OP_ADDR_LSB  = 8;
	localparam int unsigned OP_IMM_LSB   = 16;

	// Status register fields.
	localparam int unsigned ST_C_BIT     = 0;
	localparam int unsigned ST_AC_BIT    = 1;
	localparam int unsigned ST_Z_BIT     = 2;
	localparam int unsigned ST_OV_BIT    = 3;
	localparam int unsigned ST_SKIP_BIT  = 4;
	localparam int unsigned ST_BUSY_BIT  = 5;

	localparam logic [7:0]  RST_BYTE     = 8'h00;
	localparam logic [7:0]  ALL_ONES     = 8'hFF;
	localparam logic [3:0]  LAST_PAGE    = 4'hF;
	localparam logic        HAS_HIGH_PTR = 1'b1;

	typedef enum logic [4:0] {
		OP_ROTATE_LEFT_CARRY_TO_ACC  = 5'h00,
		OP_ROTATE_RIGHT_MEM          = 5'h01,
		OP_ROTATE_RIGHT_TO_ACC       = 5'h02,
		OP_ROTATE_RIGHT_CARRY_MEM    = 5'h03,
		OP_ROTATE_RIGHT_CARRY_TO_ACC = 5'h04,
		OP_SUBTRACT_BORROW_TO_ACC    = 5'h05,
		OP_SUBTRACT_BORROW_TO_MEM    = 5'h06,
		OP_SUBTRACT_TO_ACC           = 5'h07,
		OP_SUBTRACT_TO_MEM           = 5'h08,
		OP_SUBTRACT_IMM              = 5'h09,
		OP_DECREMENT_SKIP_ZERO       = 5'h0A,
		OP_DECREMENT_SKIP_ZERO_ACC   = 5'h0B,
		OP_INCREMENT_SKIP_ZERO       = 5'h0C,
		OP_INCREMENT_SKIP_ZERO_ACC   = 5'h0D,
		OP_SKIP_BIT_SET              = 5'h0E,
		OP_SKIP_BIT_CLEAR            = 5'h0F,
		OP_SKIP_IF_ZERO              = 5'h10,
		OP_COPY_SKIP_IF_ZERO         = 5'h11,
		OP_NIBBLE_SWAP_MEM           = 5'h12,
		OP_NIBBLE_SWAP_TO_ACC        = 5'h13,
		OP_BYTE_SET_MEM              = 5'h14,
		OP_BIT_SET_MEM               = 5'h15,
		OP_TABLE_READ_PAGED          = 5'h16,
		OP_TABLE_READ_LAST_PAGE      = 5'h17,
		OP_EXCLUSIVE_OR_TO_ACC       = 5'h18,
		OP_EXCLUSIVE_OR_TO_MEM       = 5'h19,
		OP_EXCLUSIVE_OR_IMM          = 5'h1A
	} rss_op_t;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_FETCH = 5'h02,
		ST_EXEC  = 5'h04,
		ST_SKIP  = 5'h08,
		ST_BUSRD = 5'h10
	} rss_state_t;

endpackage

// ===== logic/rss_mem_if.sv
// Data memory port shared by the execution unit and its byte store.
`timescale 1ns/1ps
`default_nettype none
interface rss_mem_if;
	import rss_pkg::*;
	logic [MEM_AW-1:0] addr;
	logic              rd;
	logic              wr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	modport ctrl (output addr, output rd, output wr, output wdata, input rdata);
	modport store (input addr, input rd, input wr, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== logic/rss_data_mem.sv
// Byte-wide data memory with registered read data.
`timescale 1ns/1ps
`default_nettype none
module rss_data_mem (
	input  wire logic clk,
	input  wire logic sys_rst,
	rss_mem_if.store  port
);
	import rss_pkg::*;

	logic [DATA_W-1:0] mem_array [2**MEM_AW];
	logic [DATA_W-1:0] rdata_reg;

	always_ff @(posedge clk) begin
		if (port.wr) begin
			mem_array[port.addr] <= port.wdata;
		end
	end

	// Read data appear one edge after the read strobe.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_reg <= RST_BYTE;
		end else if (port.rd) begin
			rdata_reg <= mem_array[port.addr];
		end
	end

	assign port.rdata = rdata_reg;

endmodule // rss_data_mem
`default_nettype wire

// ===== dv/rss_alu_core_asserts.sv
// Checker for the execution unit's bus, program port and completion pulses.
`timescale 1ns/1ps
`default_nettype none
module rss_alu_core_asserts (
	input wire logic                        clk,
	input wire logic                        sys_rst,
	input wire logic [rss_pkg::BUS_AW-1:0]  avs_address,
	input wire logic                        avs_read,
	input wire logic                        avs_write,
	input wire logic [rss_pkg::BUS_DW-1:0]  avs_writedata,
	input wire logic [3:0]                  avs_byteenable,
	input wire logic [rss_pkg::BUS_DW-1:0]  avs_readdata,
	input wire logic                        avs_waitrequest,
	input wire logic [rss_pkg::PROG_AW-1:0] prog_addr,
	input wire logic                        prog_rd,
	input wire logic                        skip_taken,
	input wire logic                        instr_done
);
	import rss_pkg::*;
	logic [4:0] last_op_reg;
	logic       busy_reg;
	wire        op_acc;
	wire        rd_done;
	assign op_acc = avs_write && !avs_waitrequest && avs_address == OFF_OPERATION
		&& avs_byteenable[0];
	assign rd_done = avs_read && !avs_write && !avs_waitrequest;
	// Busy from an accepted operation until its completion pulse has been seen.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			last_op_reg <= 5'h00;
			busy_reg    <= 1'b0;
		end else if (op_acc) begin
			last_op_reg <= avs_writedata[4:0];
			busy_reg    <= 1'b1;
		end else if (instr_done) begin
			busy_reg    <= 1'b0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_op_timing: assert property (op_acc |=> (avs_waitrequest && !instr_done) [*2]
		##1 (instr_done ^ skip_taken)) else $error("operation timing wrong");
	chk_skip_then_done: assert property (skip_taken |=> instr_done && !skip_taken)
		else $error("dummy cycle not followed by completion");
	chk_skip_cause: assert property (skip_taken |-> last_op_reg inside {[5'h0A:5'h11]})
		else $error("skip after a non-skip operation");
	chk_done_pulse: assert property (instr_done |=> !instr_done)
		else $error("completion pulse too long");
	chk_table_fetch: assert property (op_acc |=> prog_rd == (last_op_reg inside {5'h16, 5'h17}))
		else $error("program fetch does not match operation");
	chk_fetch_pulse: assert property (prog_rd |=> !prog_rd && $stable(prog_addr))
		else $error("program fetch pulse or address unstable");
	chk_last_page: assert property (prog_rd && last_op_reg == 5'h17 |-> prog_addr[11:8] == LAST_PAGE)
		else $error("last page fetch on wrong page");
	chk_write_fast: assert property (avs_write && !busy_reg |-> !avs_waitrequest)
		else $error("write stalled while idle");
	chk_read_wait: assert property ($rose(avs_read) && !avs_write |-> avs_waitrequest
		##[1:6] !avs_waitrequest) else $error("read wait state wrong");
	chk_read_upper: assert property (rd_done |-> avs_readdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	cov_op: cover property (op_acc);
	cov_skip: cover property (skip_taken);
	cov_fetch: cover property (prog_rd);
	cov_read: cover property (rd_done);
endmodule // rss_alu_core_asserts
bind rss_alu_core rss_alu_core_asserts rss_alu_core_asserts_i (.clk(clk), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .prog_addr(prog_addr),
	.prog_rd(prog_rd), .skip_taken(skip_taken), .instr_done(instr_done));
`default_nettype wire

// ===== dv/rss_prog_model.sv
// Program memory model answering table fetches one cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module rss_prog_model (
	input  wire logic                        clk,
	input  wire logic [rss_pkg::PROG_AW-1:0] prog_addr,
	input  wire logic                        prog_rd,
	output logic      [rss_pkg::PROG_DW-1:0] prog_data
);
	import rss_pkg::*;
	initial prog_data = 16'h0000;
	always @(posedge clk) begin
		if (prog_rd) begin
			prog_data <= {prog_addr[11:4] ^ 8'hC3, prog_addr[7:0] ^ 8'h5A};
		end else begin
			prog_data <= ~prog_data;
		end
	end
endmodule // rss_prog_model
`default_nettype wire

// ===== dv/test_rotate_subtract_skip_alu_ops.sv
// Self-checking bench for the execution unit with random and corner operations.
`timescale 1ns/1ps
`default_nettype none
module test_rotate_subtract_skip_alu_ops;
	import rss_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [11:0] prog_addr;
	logic        prog_rd;
	logic [15:0] prog_data;
	logic        skip_taken;
	logic        instr_done;
	int          n_errors = 0;
	int          checks = 0;
	int          seed = 32'h35162D43;
	int          cyc = 0;
	logic [7:0]  e_acc = 8'h00;
	logic [3:0]  e_fl = 4'h0;
	logic [7:0]  e_tl = 8'h00;
	logic [7:0]  e_th = 8'h00;
	logic [7:0]  e_table_high_byte_reg = 8'h00;
	logic        e_sk = 1'b0;
	logic [7:0]  e_mem [16];
	logic [7:0]  ra [5] = '{OFF_ACC, OFF_STATUS, OFF_TBL_LOW, OFF_TBL_HIGH, OFF_TBL_DATA};
	rss_alu_core rss_alu_core_i (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .prog_addr(prog_addr), .prog_rd(prog_rd),
		.prog_data(prog_data), .skip_taken(skip_taken), .instr_done(instr_done));
	rss_prog_model rss_prog_model_i (.clk(clk), .prog_addr(prog_addr), .prog_rd(prog_rd),
		.prog_data(prog_data));
	always #20 clk = ~clk;
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// The request stands until waitrequest is seen low at a rising edge; read data are taken there.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hF, q);
	endtask
	task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hF, q);
		cmp(nm, e, q);
	endtask
	function automatic logic [7:0] cv(input logic [31:0] r);
		case (r[10:8])
			3'h0: return 8'h00;
			3'h1: return 8'hFF;
			3'h2: return 8'h01;
			3'h3: return 8'h80;
			3'h4: return 8'h7F;
			default: return r[7:0];
		endcase
	endfunction
	function automatic void expect_op(input logic [4:0] o, input logic [3:0] ix,
		input logic [2:0] bt, input logic [7:0] im);
		logic [7:0] m, a, b, x, dm, pm;
		logic [8:0] d;
		logic [4:0] n;
		logic       bi;
		logic [15:0] w;
		m = e_mem[ix];
		a = e_acc;
		b = (o == 5'h09) ? im : m;
		x = a ^ ((o == 5'h1A) ? im : m);
		bi = (o == 5'h05 || o == 5'h06) ? ~e_fl[0] : 1'b0;
		d = {1'b0, a} - {1'b0, b} - 9'(bi);
		n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(bi);
		dm = m - 8'h01;
		pm = m + 8'h01;
		w = {(o == 5'h17) ? LAST_PAGE : e_th[3:0], e_tl};
		w = {w[11:4] ^ 8'hC3, w[7:0] ^ 8'h5A};
		e_sk = 1'b0;
		case (o)
			5'h00: {e_acc, e_fl[0]} = {m[6:0], e_fl[0], m[7]};
			5'h01: e_mem[ix] = {m[0], m[7:1]};
			5'h02: e_acc = {m[0], m[7:1]};
			5'h03: {e_mem[ix], e_fl[0]} = {e_fl[0], m};
			5'h04: {e_acc, e_fl[0]} = {e_fl[0], m};
			5'h05, 5'h07, 5'h09: e_acc = d[7:0];
			5'h06, 5'h08: e_mem[ix] = d[7:0];
			5'h0A: {e_mem[ix], e_sk} = {dm, dm == 8'h00};
			5'h0B: {e_acc, e_sk} = {dm, dm == 8'h00};
			5'h0C: {e_mem[ix], e_sk} = {pm, pm == 8'h00};
			5'h0D: {e_acc, e_sk} = {pm, pm == 8'h00};
			5'h0E: e_sk = m[bt];
			5'h0F: e_sk = ~m[bt];
			5'h10: e_sk = m == 8'h00;
			5'h11: {e_acc, e_sk} = {m, m == 8'h00};
			5'h12: e_mem[ix] = {m[3:0], m[7:4]};
			5'h13: e_acc = {m[3:0], m[7:4]};
			5'h14: e_mem[ix] = ALL_ONES;
			5'h15: e_mem[ix][bt] = 1'b1;
			5'h16, 5'h17: {e_table_high_byte_reg, e_mem[ix]} = w;
			5'h18, 5'h1A: e_acc = x;
			5'h19: e_mem[ix] = x;
			default: ;
		endcase
		if (o >= 5'h05 && o <= 5'h09) begin
			e_fl = {(a[7] ^ b[7]) & (a[7] ^ d[7]), d[7:0] == 8'h00, ~n[4], ~d[8]};
		end
		if (o >= 5'h18 && o <= 5'h1A) begin
			e_fl[2] = x == 8'h00;
		end
	endfunction
	initial begin
		logic [31:0] q;
		logic [4:0]  o;
		logic [3:0]  ix;
		logic [2:0]  bt;
		logic [7:0]  im;
		logic        sk;
		logic        dn;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		foreach (ra[i]) chk("reset value", ra[i], 32'h0);
		wr(8'h20, 32'h000000FF);
		chk("unmapped", 8'h20, 32'h0);
		bus(1'b1, OFF_ACC, 32'h0000005A, 4'hE, q);
		chk("lane gated acc", OFF_ACC, 32'h0);
		wr(OFF_TBL_DATA, 32'h000000FF);
		chk("table high ro", OFF_TBL_DATA, 32'h0);
		wr(OFF_STATUS, 32'h000000FF);
		chk("status ro bits", OFF_STATUS, 32'h0000000F);
		$display("Test registers done");
		for (int i = 0; i < 96; i++) begin
			o = (i < 32) ? 5'(i) : 5'($random(seed));
			q = $random(seed);
			ix = q[3:0];
			bt = q[6:4];
			im = cv($random(seed));
			e_mem[ix] = cv($random(seed));
			q = $random(seed);
			wr({MEM_WIN_SEL, ix, 2'h0}, {q[31:8], e_mem[ix]});
			e_acc = cv($random(seed));
			wr(OFF_ACC, {24'h0, e_acc});
			q = $random(seed);
			e_fl = q[3:0];
			wr(OFF_STATUS, q);
			q = $random(seed);
			{e_th, e_tl} = q[15:0];
			wr(OFF_TBL_LOW, {24'h0, e_tl});
			wr(OFF_TBL_HIGH, {24'h0, e_th});
			chk("table pointer high", OFF_TBL_HIGH, {28'h0, e_th[3:0]});
			wr(OFF_OPERATION, {8'h00, im, 4'h0, ix, bt, o});
			expect_op(o, ix, bt, im);
			sk = 1'b0;
			dn = 1'b0;
			for (int k = 0; k < 8 && !dn; k++) begin
				@(negedge clk);
				if (skip_taken === 1'b1) sk = 1'b1;
				if (instr_done === 1'b1) dn = 1'b1;
			end
			@(posedge clk);
			cmp("done", 32'h1, {31'h0, dn});
			cmp("skip", {31'h0, e_sk}, {31'h0, sk});
			chk("acc", OFF_ACC, {24'h0, e_acc});
			chk("status", OFF_STATUS, {27'h0, e_sk, e_fl});
			chk("memory", {MEM_WIN_SEL, ix, 2'h0}, {24'h0, e_mem[ix]});
			chk("table high", OFF_TBL_DATA, {24'h0, e_table_high_byte_reg});
		end
		$display("Test operations done");
		report_and_stop();
	end
endmodule // test_rotate_subtract_skip_alu_ops
`default_nettype wire
